// ---- hdl/hstd_pkg.sv ----
// Purpose: Constants shared by the async transfer descriptor engine
// Assumes: Descriptor held as four 32-bit words, one APB word each
// Notes:   Bit positions are relative to the containing 32-bit word
package hstd_pkg;

    // Register byte offsets of the descriptor words
    localparam logic [7:0] OFF_DW0 = 8'h00;
    localparam logic [7:0] OFF_DW1 = 8'h04;
    localparam logic [7:0] OFF_DW2 = 8'h08;
    localparam logic [7:0] OFF_DW3 = 8'h0C;

    // Word 0 fields
    localparam int DW0_VALID   = 0;
    localparam int DW0_REQ_LSB = 3;
    localparam int DW0_MPL_LSB = 18;
    localparam int DW0_EP0     = 31;
    // Word 1 fields
    localparam int DW1_EP_LSB  = 0;
    localparam int DW1_DEV_LSB = 3;
    localparam int DW1_TOK_LSB = 10;
    localparam int DW1_TYP_LSB = 12;
    localparam int DW1_SPLIT   = 14;
    // Word 2 fields
    localparam int DW2_BUF_LSB = 8;
    localparam int DW2_RL_LSB  = 25;
    // Word 3 fields
    localparam int DW3_DONE_LSB = 0;
    localparam int DW3_NAK_LSB  = 19;
    localparam int DW3_CERR_LSB = 23;
    localparam int DW3_ERR      = 28;
    localparam int DW3_HALT     = 30;
    localparam int DW3_ACT      = 31;

    // Value of every descriptor word after reset
    localparam logic [31:0] DW_RESET = 32'h0000_0000;

    // Buffer address translation: (cpu address - base) / 8
    localparam logic [17:0] BUF_CPU_BASE = 18'h0_0400;
    localparam int          BUF_SHIFT    = 3;

    // Token codes
    typedef enum logic [1:0] {
        TOK_OUT   = 2'b00,
        TOK_IN    = 2'b01,
        TOK_SETUP = 2'b10,
        TOK_PING  = 2'b11
    } hstd_token_t;

    // Transfer types served by this format
    localparam logic [1:0] TYPE_CONTROL = 2'b00;
    localparam logic [1:0] TYPE_BULK    = 2'b10;

    // Handshake results reported by the link engine
    typedef enum logic [1:0] {
        RES_ACK   = 2'b00,
        RES_NAK   = 2'b01,
        RES_ERR   = 2'b10,
        RES_STALL = 2'b11
    } hstd_result_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } hstd_state_t;

    // Whole state of the engine
    typedef struct packed {
        hstd_state_t fsm;
        logic [31:0] dw0;
        logic [31:0] dw1;
        logic [31:0] dw2;
        logic [31:0] dw3;
        logic [31:0] rdata;
    } hstd_regs_t;

endpackage : hstd_pkg

// ---- hdl/hstd_apb_port.sv ----
// Purpose: APB slave decode for the descriptor registers
// Assumes: APB3 signalling, 32-bit words, no byte strobes
// Notes:   Mapped writes wait while the engine runs; reads never wait
`timescale 1ns/1ps
module hstd_apb_port
    import hstd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic              i_idle,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic                   o_setup,
    output logic                   o_wr_en,
    output logic [1:0]             o_index
);

    // Address must at least span the four words
    if (ADDR_W < 4) begin : g_chk
        $error("hstd_apb_port: ADDR_W below 4");
    end

    logic mapped;

    // Unmapped when any bit above the word index or a low bit is set
    assign mapped = (i_paddr[ADDR_W-1:4] == '0) && (i_paddr[1:0] == 2'h0);
    assign o_index = i_paddr[3:2];
    assign o_setup = i_psel && !i_penable;
    // Holding writes while busy avoids racing the hardware updates
    assign o_pready = !(i_pwrite && mapped) || i_idle;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign o_wr_en = i_psel && i_penable && i_pwrite && mapped && i_idle;

endmodule : hstd_apb_port

// ---- hdl/hstd_engine.sv ----
// Purpose: Executes one high-speed bulk/control transfer descriptor
// Assumes: Link engine reports one handshake per issued token
// Notes:   Descriptor words are APB registers at byte offsets 0..C
//
// Contract
// - Two-bit retry count; 00 means no retry, hardware decrements it
// - NAK count reaching zero with nonzero reload clears the valid bit
// - Every acknowledged transaction reloads the NAK count
// - Reload of zero means NAK count ignored, never invalidates
// - Hardware writes the bytes moved into the fifteen-bit done count
// - Payload start is buffer address: (cpu address - 400h) / 8
// - Split bit 0 runs plain high-speed, 1 runs split transaction
// - Transfer type 00 is control, 10 is bulk
// - Token field picks OUT, IN, SETUP or PING
// - PING code comes only from hardware, never from software
// - Each transaction goes to the seven-bit function number
// - Endpoint upper three bits here, lowest bit in word zero
// - Valid clears when the descriptor completes or fails fatally
// - Exhausted errors set the error flag, clear active and valid
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module hstd_engine
    import hstd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic                   o_token_valid,
    input  wire logic              i_token_ready,
    output logic [1:0]             o_token_kind,
    output logic [6:0]             o_token_addr,
    output logic [3:0]             o_token_endp,
    output logic                   o_split,
    output logic [1:0]             o_xfer_type,
    output logic [15:0]            o_buf_addr,
    input  wire logic              i_result_valid,
    input  wire logic [1:0]        i_result_code,
    input  wire logic [14:0]       i_result_bytes
);

    hstd_regs_t r;
    hstd_regs_t next_r;
    logic       setup;
    logic       wr_en;
    logic [1:0] index;

    // Field views of the current descriptor
    logic [3:0]  nak;
    logic [3:0]  reload;
    logic [1:0]  cerr;
    logic [1:0]  token;
    logic [1:0]  xtype;
    logic [14:0] done;
    logic [14:0] req;
    logic [10:0] mpl;
    logic        valid;
    logic        active;

    assign nak    = r.dw3[DW3_NAK_LSB +: 4];
    assign reload = r.dw2[DW2_RL_LSB +: 4];
    assign cerr   = r.dw3[DW3_CERR_LSB +: 2];
    assign token  = r.dw1[DW1_TOK_LSB +: 2];
    assign xtype  = r.dw1[DW1_TYP_LSB +: 2];
    assign done   = r.dw3[DW3_DONE_LSB +: 15];
    assign req    = r.dw0[DW0_REQ_LSB +: 15];
    assign mpl    = r.dw0[DW0_MPL_LSB +: 11];
    assign valid  = r.dw0[DW0_VALID];
    assign active = r.dw3[DW3_ACT];

    // Word select, used by the read capture
    function automatic logic [31:0] pick(input hstd_regs_t s,
                                         input logic [1:0] i);
        case (i)
            2'h0:    pick = s.dw0;
            2'h1:    pick = s.dw1;
            2'h2:    pick = s.dw2;
            default: pick = s.dw3;
        endcase
    endfunction : pick

    // Byte total saturates rather than wrapping past the field
    function automatic logic [14:0] add_sat(input logic [14:0] a,
                                            input logic [14:0] b);
        logic [15:0] s;
        s = {1'b0, a} + {1'b0, b};
        add_sat = s[15] ? 15'h7FFF : s[14:0];
    endfunction : add_sat

    hstd_apb_port #(
        .ADDR_W    (ADDR_W)
    ) u_port (
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .i_idle    (r.fsm == ST_IDLE),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr),
        .o_setup   (setup),
        .o_wr_en   (wr_en),
        .o_index   (index)
    );

    // Next-state logic of the whole engine
    always_comb begin
        logic [14:0] sum;
        logic        fin;
        sum = add_sat(done, i_result_bytes);
        fin = 1'b0;
        next_r = r;
        // Read data captured in the setup phase, stable in access
        if (setup) begin
            next_r.rdata = pick(r, index);
        end
        case (r.fsm)
            ST_IDLE: begin
                if (wr_en) begin
                    case (index)
                        2'h0: next_r.dw0 = i_pwdata;
                        2'h1: begin
                            next_r.dw1 = i_pwdata;
                            // Software PING code falls back to OUT
                            if (i_pwdata[DW1_TOK_LSB +: 2] == TOK_PING) begin
                                next_r.dw1[DW1_TOK_LSB +: 2] = TOK_OUT;
                            end
                        end
                        2'h2: next_r.dw2 = i_pwdata;
                        default: next_r.dw3 = i_pwdata;
                    endcase
                end else if (valid && active) begin
                    // Only control and bulk run in this format
                    if (xtype == TYPE_CONTROL || xtype == TYPE_BULK) begin
                        next_r.fsm = ST_ISSUE;
                    end else begin
                        next_r.dw3[DW3_ERR] = 1'b1;
                        next_r.dw3[DW3_ACT] = 1'b0;
                        next_r.dw0[DW0_VALID] = 1'b0;
                    end
                end
            end
            ST_ISSUE: begin
                if (i_token_ready) begin
                    next_r.fsm = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (i_result_valid) begin
                    next_r.fsm = ST_IDLE;
                    case (i_result_code)
                        RES_ACK: begin
                            next_r.dw3[DW3_NAK_LSB +: 4] = reload;
                            if (token == TOK_PING) begin
                                // Endpoint has room again: resume data
                                next_r.dw1[DW1_TOK_LSB +: 2] = TOK_OUT;
                            end else begin
                                next_r.dw3[DW3_DONE_LSB +: 15] = sum;
                                // Short IN packet also ends the transfer
                                fin = (sum >= req) || (token == TOK_IN &&
                                      {4'h0, i_result_bytes} < {4'h0, mpl});
                            end
                        end
                        RES_NAK: begin
                            // Zero reload leaves the count alone
                            if (reload != 4'h0) begin
                                if (nak <= 4'h1) begin
                                    next_r.dw3[DW3_NAK_LSB +: 4] = 4'h0;
                                    next_r.dw0[DW0_VALID] = 1'b0;
                                end else begin
                                    next_r.dw3[DW3_NAK_LSB +: 4] =
                                        nak - 4'h1;
                                end
                            end
                            // Plain high-speed OUT probes with PING next
                            if (token == TOK_OUT && !r.dw1[DW1_SPLIT]) begin
                                next_r.dw1[DW1_TOK_LSB +: 2] = TOK_PING;
                            end
                        end
                        RES_ERR: begin
                            if (cerr != 2'h0) begin
                                next_r.dw3[DW3_CERR_LSB +: 2] =
                                    cerr - 2'h1;
                            end else begin
                                next_r.dw3[DW3_ERR] = 1'b1;
                                fin = 1'b1;
                            end
                        end
                        default: begin
                            next_r.dw3[DW3_HALT] = 1'b1;
                            fin = 1'b1;
                        end
                    endcase
                    if (fin) begin
                        next_r.dw0[DW0_VALID] = 1'b0;
                        next_r.dw3[DW3_ACT] = 1'b0;
                    end
                end
            end
            default: next_r.fsm = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            r.fsm   <= ST_IDLE;
            r.dw0   <= DW_RESET;
            r.dw1   <= DW_RESET;
            r.dw2   <= DW_RESET;
            r.dw3   <= DW_RESET;
            r.rdata <= DW_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Token request toward the link, straight from the descriptor
    assign o_prdata      = r.rdata;
    assign o_token_valid = (r.fsm == ST_ISSUE);
    assign o_token_kind  = token;
    assign o_token_addr  = r.dw1[DW1_DEV_LSB +: 7];
    assign o_token_endp  = {r.dw1[DW1_EP_LSB +: 3], r.dw0[DW0_EP0]};
    assign o_split       = r.dw1[DW1_SPLIT];
    assign o_xfer_type   = xtype;
    // Already a buffer word address; no cpu translation here
    assign o_buf_addr    = r.dw2[DW2_BUF_LSB +: 16];

    // Checks
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    logic res_now;
    assign res_now = (r.fsm == ST_WAIT) && i_result_valid;

    a_nak_reload_ack: assert property (
        res_now && i_result_code == RES_ACK |=> nak == $past(reload))
        else $error("NAK count not reloaded on ACK");

    a_nak_count_down: assert property (
        res_now && i_result_code == RES_NAK && reload != 4'h0 &&
        nak > 4'h1 |=> nak == $past(nak) - 4'h1 && valid)
        else $error("NAK count did not step down");

    a_nak_stop_valid: assert property (
        res_now && i_result_code == RES_NAK && reload != 4'h0 &&
        nak == 4'h1 |=> !valid ##1 r.fsm == ST_IDLE)
        else $error("Valid not cleared at NAK count zero");

    a_nak_ignored: assert property (
        res_now && i_result_code == RES_NAK && reload == 4'h0
        |=> $stable(nak) && valid)
        else $error("NAK count used with zero reload");

    a_bytes_total: assert property (
        res_now && i_result_code == RES_ACK && token != TOK_PING
        |=> done == add_sat($past(done), $past(i_result_bytes)))
        else $error("Byte total wrong after ACK");

    a_err_retry: assert property (
        res_now && i_result_code == RES_ERR && cerr != 2'h0
        |=> cerr == $past(cerr) - 2'h1 && valid && !r.dw3[DW3_ERR])
        else $error("Retry count not decremented");

    a_err_fatal: assert property (
        res_now && i_result_code == RES_ERR && cerr == 2'h0
        |=> r.dw3[DW3_ERR] && !active && !valid)
        else $error("Exhausted error not flagged");

    a_done_clear: assert property (
        res_now && i_result_code == RES_ACK && token != TOK_PING &&
        add_sat(done, i_result_bytes) >= req |=> !valid && !active)
        else $error("Completed descriptor still valid");

    a_type_served: assert property (
        o_token_valid |-> xtype == TYPE_CONTROL || xtype == TYPE_BULK)
        else $error("Unsupported transfer type issued");

    a_ping_origin: assert property (
        wr_en && index == 2'h1 |=> token != TOK_PING)
        else $error("Software wrote PING token");

    a_token_fields: assert property (
        o_token_valid && !i_token_ready |=>
        $stable(o_token_addr) && $stable(o_token_endp) && o_token_valid)
        else $error("Token request changed while pending");

    // Launch condition as the idle state sees it
    logic launch_seen;
    assign launch_seen = (r.fsm == ST_IDLE) && !wr_en && valid && active;

    a_launch_issue: assert property (
        launch_seen && (xtype == TYPE_CONTROL || xtype == TYPE_BULK)
        |=> o_token_valid)
        else $error("Launch did not issue a token");

    a_type_refused: assert property (
        launch_seen && xtype != TYPE_CONTROL && xtype != TYPE_BULK
        |=> r.dw3[DW3_ERR] && !active && !valid && !o_token_valid)
        else $error("Unsupported transfer type not refused");

    a_issue_wait: assert property (
        o_token_valid && i_token_ready
        |=> r.fsm == ST_WAIT && !o_token_valid)
        else $error("Accepted token still pending");

    a_token_hold: assert property (
        o_token_valid && !i_token_ready |=>
        $stable(o_token_kind) && $stable(o_buf_addr) && $stable(o_split))
        else $error("Token kind or buffer changed while pending");

    a_ping_resume: assert property (
        res_now && i_result_code == RES_ACK && token == TOK_PING
        |=> token == TOK_OUT && $stable(done) && valid)
        else $error("PING answer did not resume data");

    a_ping_probe: assert property (
        res_now && i_result_code == RES_NAK && token == TOK_OUT && !o_split
        |=> token == TOK_PING)
        else $error("Plain OUT NAK not followed by PING");

    a_split_no_ping: assert property (
        res_now && i_result_code == RES_NAK && o_split
        |=> token == $past(token))
        else $error("Split transaction switched token");

    a_short_in_done: assert property (
        res_now && i_result_code == RES_ACK && token == TOK_IN &&
        {4'h0, i_result_bytes} < {4'h0, mpl} |=> !valid && !active)
        else $error("Short IN packet did not end descriptor");

    a_stall_halt: assert property (
        res_now && i_result_code == RES_STALL
        |=> r.dw3[DW3_HALT] && !valid && !active)
        else $error("STALL did not halt descriptor");

    a_nak_keep_active: assert property (
        res_now && i_result_code == RES_NAK |=> active)
        else $error("NAK changed the active bit");

    c_complete: cover property (
        res_now && i_result_code == RES_ACK ##1 !valid);
    c_nak_stop: cover property (
        res_now && i_result_code == RES_NAK ##1 !valid);
    c_ping: cover property (
        o_token_valid && o_token_kind == TOK_PING);
    c_fatal: cover property (
        res_now && i_result_code == RES_ERR && cerr == 2'h0);
    c_stall: cover property (
        res_now && i_result_code == RES_STALL);

endmodule : hstd_engine

// ---- testbench/hstd_ep_model.sv ----
// Purpose: Endpoint model answering tokens issued by the engine
// Assumes: One handshake result per accepted token
// Notes:   Answer code, byte count and pace are set by the bench
`timescale 1ns/1ps
module hstd_ep_model (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_token_valid,
    input  wire logic [1:0]  i_code,
    input  wire logic [14:0] i_bytes,
    input  wire logic [1:0]  i_delay,
    output logic             o_token_ready  = 1'b0,
    output logic             o_result_valid = 1'b0,
    output logic [1:0]       o_result_code  = 2'h0,
    output logic [14:0]      o_result_bytes = 15'h0000
);
    logic [1:0] wait_cnt = 2'h0;
    logic       busy     = 1'b0;

    // Idle result lines toggle so a stale answer never looks valid
    always @(posedge i_clock) begin
        o_token_ready  <= 1'b0;
        o_result_valid <= 1'b0;
        o_result_code  <= ~o_result_code;
        o_result_bytes <= ~o_result_bytes;
        if (i_rst) begin
            busy     <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (busy) begin
            if (wait_cnt >= i_delay) begin
                busy           <= 1'b0;
                wait_cnt       <= 2'h0;
                o_result_valid <= 1'b1;
                o_result_code  <= i_code;
                o_result_bytes <= i_bytes;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end else if (i_token_valid) begin
            // Ready was high with valid at this edge: token taken
            if (o_token_ready) begin
                busy     <= 1'b1;
                wait_cnt <= 2'h0;
            end else if (wait_cnt >= i_delay) begin
                o_token_ready <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule : hstd_ep_model

// ---- testbench/tb_hstd_engine.sv ----
// Purpose: Self-checking bench for the async descriptor engine
// Assumes: Endpoint model answers each token as commanded
// Notes:   Random fields come from a fixed seed
`timescale 1ns/1ps
module tb_hstd_engine;
    import hstd_pkg::*;
    logic        i_clock   = 1'b0;
    logic        i_rst     = 1'b1;
    logic        i_psel    = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite  = 1'b0;
    logic [7:0]  i_paddr   = 8'h00;
    logic [31:0] i_pwdata  = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic        o_pready, o_pslverr, o_token_valid, i_token_ready;
    logic [1:0]  o_token_kind, o_xfer_type, i_result_code;
    logic [6:0]  o_token_addr;
    logic [3:0]  o_token_endp, rl;
    logic        o_split, i_result_valid, perr;
    logic [15:0] o_buf_addr;
    logic [14:0] i_result_bytes, b;
    logic [14:0] cmd_bytes = 15'h0000;
    logic [1:0]  cmd_code  = 2'h0;
    logic [1:0]  cmd_delay = 2'h0;
    logic [1:0]  sw_code   = 2'h0;
    logic [1:0]  kinds [8];
    logic [31:0] w0, w1, w2, w3, q;
    logic [29:0] fld, exp_fld;
    int          ntok, sw_at, n_errors, n_tests;

    hstd_engine #(.ADDR_W(8)) hstd_engine_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_token_valid(o_token_valid),
        .i_token_ready(i_token_ready), .o_token_kind(o_token_kind),
        .o_token_addr(o_token_addr), .o_token_endp(o_token_endp),
        .o_split(o_split), .o_xfer_type(o_xfer_type),
        .o_buf_addr(o_buf_addr), .i_result_valid(i_result_valid),
        .i_result_code(i_result_code), .i_result_bytes(i_result_bytes));

    hstd_ep_model hstd_ep_model_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_token_valid(o_token_valid),
        .i_code(cmd_code), .i_bytes(cmd_bytes), .i_delay(cmd_delay),
        .o_token_ready(i_token_ready), .o_result_valid(i_result_valid),
        .o_result_code(i_result_code), .o_result_bytes(i_result_bytes));

    always #10 i_clock = ~i_clock;

    // Log each accepted token; the answer code may switch midway
    always @(posedge i_clock) begin
        if (o_token_valid && i_token_ready) begin
            if (ntok < 8) kinds[ntok] = o_token_kind;
            if (ntok == 0) fld = {o_token_addr, o_token_endp, o_split,
                                  o_xfer_type, o_buf_addr};
            ntok = ntok + 1;
            if (ntok == sw_at) cmd_code <= sw_code;
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask : chk

    // Pready, read data and slave error are taken at one rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge i_clock);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin @(posedge i_clock); t++; end
        while (o_pready !== 1'b1 && t < 500);
        if (t >= 500) n_errors++;
        r    = o_prdata;
        perr = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr

    // Buffer word address from a processor byte address
    function automatic logic [15:0] buf_of(input logic [17:0] cpu);
        return 16'((cpu - 18'h0_0400) >> 3);
    endfunction : buf_of

    // Random descriptor that software may legally launch
    task automatic build(input logic [1:0] tk, input logic sp,
                         input logic [3:0] r, input logic [1:0] ce);
        logic [6:0]  ad;
        logic [3:0]  ep;
        logic [1:0]  ty;
        logic [15:0] ba;
        ad = 7'($urandom);
        ep = 4'($urandom);
        ty = $urandom_range(0, 1) ? TYPE_BULK : TYPE_CONTROL;
        ba = buf_of(18'h0_0400 + 18'($urandom_range(0, 8191) * 8));
        b  = 15'($urandom_range(1, 511));
        rl = r;
        w0 = {ep[0], 2'b01, 11'h200, b, 2'b00, 1'b1};
        w1 = {17'h0_0000, sp, ty, tk, ad, ep[3:1]};
        w2 = {3'b000, r, 1'b0, ba, 8'h00};
        w3 = {1'b1, 6'h00, ce, r, 4'h0, 15'h0000};
        exp_fld = {ad, ep, sp, ty, ba};
        cmd_bytes <= b;
    endtask : build

    // Launch, then poll until hardware drops the valid bit
    task automatic run(input logic [1:0] c0, input int sw,
                       input logic [1:0] c1);
        int t;
        ntok = 0;
        sw_at = sw;
        sw_code = c1;
        cmd_code <= c0;
        cmd_delay <= 2'($urandom);
        wr(OFF_DW1, w1);
        wr(OFF_DW2, w2);
        wr(OFF_DW3, w3);
        wr(OFF_DW0, w0);
        t = 0;
        do begin apb(1'b0, OFF_DW0, 32'h0000_0000, q); t++; end
        while (q[DW0_VALID] !== 1'b0 && t < 300);
        if (t >= 300) n_errors++;
    endtask : run

    task automatic nak_case(input logic [3:0] r, input int sw,
                            input logic [1:0] c1, input int nt);
        logic ack;
        build(TOK_IN, 1'b1, r, 2'b11);
        ack = (c1 == RES_ACK);
        run(RES_NAK, sw, c1);
        chk(32'(ntok), 32'(nt));
        apb(1'b0, OFF_DW3, 32'h0000_0000, q);
        chk(q, {!ack, 6'h00, 2'b11, ack ? r : 4'h0, 4'h0,
                ack ? b : 15'h0000});
    endtask : nak_case

    initial begin
        q = $urandom(99181);
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        // All words clear after reset; unmapped writes are refused
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0000_0000, q);
            chk(q, DW_RESET);
        end
        wr(8'h10, 32'hFFFF_FFFE);
        chk(32'(perr), 32'h0000_0001);
        apb(1'b0, OFF_DW0, 32'h0000_0000, q);
        chk(q, DW_RESET);
        wr(OFF_DW1, 32'h0000_0C00);
        apb(1'b0, OFF_DW1, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        // Each software token code with random target fields
        for (int k = 0; k < 3; k++) begin
            build(2'(k), 1'($urandom), 4'($urandom_range(1, 15)), 2'b11);
            run(RES_ACK, 99, RES_ACK);
            chk(q, w0 & 32'hFFFF_FFFE);
            chk(32'(kinds[0]), 32'(k));
            chk(32'(fld), 32'(exp_fld));
            apb(1'b0, OFF_DW3, 32'h0000_0000, q);
            chk(q, {1'b0, 6'h00, 2'b11, rl, 4'h0, b});
        end
        nak_case(4'h3, 99, RES_NAK, 3);
        nak_case(4'h0, 5, RES_ACK, 5);
        nak_case(4'h3, 2, RES_ACK, 2);
        // NAK on a plain OUT probes with PING before resending
        build(TOK_OUT, 1'b0, 4'h0, 2'b11);
        run(RES_NAK, 2, RES_ACK);
        chk(32'({kinds[1], kinds[2]}), 32'({TOK_PING, TOK_OUT}));
        // Errors retry while the count lasts, then fail for good
        for (int r = 0; r < 4; r++) begin
            build(TOK_IN, 1'b1, 4'h2, 2'(r));
            run(RES_ERR, 99, RES_ERR);
            chk(32'(ntok), 32'(r + 1));
            apb(1'b0, OFF_DW3, 32'h0000_0000, q);
            chk(q, {4'h1, 3'b000, 2'b00, 4'h2, 4'h0, 15'h0000});
        end
        // Isochronous class code is refused without any token
        build(TOK_IN, 1'b0, 4'h1, 2'b00);
        w1[DW1_TYP_LSB +: 2] = 2'b01;
        run(RES_ACK, 99, RES_ACK);
        chk(32'(ntok), 32'h0000_0000);
        apb(1'b0, OFF_DW3, 32'h0000_0000, q);
        chk(q, {4'h1, 3'b000, 2'b00, 4'h1, 4'h0, 15'h0000});
        // A stalled endpoint halts the descriptor after one token
        build(TOK_OUT, 1'b1, 4'h2, 2'b11);
        run(RES_STALL, 99, RES_STALL);
        chk(32'(ntok), 32'h0000_0001);
        apb(1'b0, OFF_DW3, 32'h0000_0000, q);
        chk(q, {4'h4, 3'b000, 2'b11, 4'h2, 4'h0, 15'h0000});
        report_and_stop();
    end

    // Watchdog well beyond the expected length of the run
    initial begin
        repeat (50000) @(posedge i_clock);
        n_errors++;
        report_and_stop();
    end
endmodule : tb_hstd_engine
